// ===== src/ssb_pkg.sv
// Overview of operation
// RL1 - master holds select low whole message
// RL2 - master selects slaves via software port pins
// RL3 - master selects only one slave at once
// RL4 - unselected slave floats its miso output
// RL5 - master uses select and fault flag
// RL6 - select disable ignores pin, no fault
// RL7 - slave cpha one, disable: always selected
// RL8 - clearing select disable keeps fault flag
// RL9 - slave cpha zero starts on select
// RL10 - software avoids disable with cpha zero
// RL11 - master clock divides input by code
// RL12 - software never programs codes 000, 111
// RL13 - master select low sets fault, stops drive
package ssb_pkg;
  localparam logic [2:0] DIV_RSVD_LO = 3'h0;
  localparam logic [2:0] DIV_RSVD_HI = 3'h7;
  localparam int         DIV_WIDTH   = 7;
  localparam logic [6:0] CNT_RESET   = 7'h00;
  localparam int         CNT_MAX_WIDTH = 16;
  localparam int         SYNC_DEPTH  = 2;
  localparam logic [2:0] DIV_CODE_4   = 3'h1;
  localparam logic [2:0] DIV_CODE_8   = 3'h2;
  localparam logic [2:0] DIV_CODE_16  = 3'h3;
  localparam logic [2:0] DIV_CODE_32  = 3'h4;
  localparam logic [2:0] DIV_CODE_64  = 3'h5;
  localparam logic [2:0] DIV_CODE_128 = 3'h6;
  localparam logic [6:0] HALF_DIV_4   = 7'h01;
  localparam logic [6:0] HALF_DIV_8   = 7'h03;
  localparam logic [6:0] HALF_DIV_16  = 7'h07;
  localparam logic [6:0] HALF_DIV_32  = 7'h0f;
  localparam logic [6:0] HALF_DIV_64  = 7'h1f;
  localparam logic [6:0] HALF_DIV_128 = 7'h3f;
endpackage

// ===== src/ssb_select_baud.sv
`timescale 1ns/100ps
module ssb_select_baud #(
  parameter int CNT_WIDTH   = ssb_pkg::DIV_WIDTH,
  parameter int SYNC_STAGES = ssb_pkg::SYNC_DEPTH
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // control bits
  input  wire logic       master_enable,
  input  wire logic       clock_phase,
  input  wire logic       select_input_disable,
  input  wire logic [2:0] clock_divider_select,
  input  wire logic       fault_clear,
  // pins
  input  wire logic       select_pin_n,
  input  wire logic       miso_data,
  input  wire logic       mosi_data,
  // status and outputs
  output logic            mode_fault_flag,
  output logic            slave_selected,
  output logic            transfer_start,
  output logic            sck_out,
  output logic            sck_oe,
  output logic            mosi_out,
  output logic            mosi_oe,
  output logic            miso_out,
  output logic            miso_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // parameter checks
  if (CNT_WIDTH < ssb_pkg::DIV_WIDTH) begin : gen_cnt_low
    $error("counter too narrow for the slowest divider");
  end

  if (CNT_WIDTH > ssb_pkg::CNT_MAX_WIDTH) begin : gen_cnt_high
    $error("counter wider than the divider needs");
  end

  if (SYNC_STAGES < 2) begin : gen_sync_check
    $error("select pin needs at least two synchroniser stages");
  end

  ////////////////////////////////////////////////////////////////////////////
  // last stage of the select pin synchroniser
  localparam int LAST_SYNC = SYNC_STAGES - 1;

  ////////////////////////////////////////////////////////////////////////////
  // port role, one-hot
  typedef enum logic [2:0] {
    ROLE_SLAVE  = 3'h1,
    ROLE_MASTER = 3'h2,
    ROLE_FAULT  = 3'h4
  } ssb_role_t;

  // all registered state
  typedef struct packed {
    // pin synchroniser
    logic [SYNC_STAGES-1:0] sync;
    // role and divider
    ssb_role_t              role;
    logic [CNT_WIDTH-1:0]   cnt;
    // status
    logic                   fault;
    logic                   selected;
    logic                   start;
    // pin drivers
    logic                   sck;
    logic                   sck_oe;
    logic                   mosi;
    logic                   mosi_oe;
    logic                   miso;
    logic                   miso_oe;
  } ssb_state_t;

  ssb_state_t state;
  ssb_state_t next_state;

  ////////////////////////////////////////////////////////////////////////////
  // half period of the divided clock, in input clock cycles, minus one
  function automatic logic [CNT_WIDTH-1:0] half_period(input logic [2:0] code);
    case (code)
      ssb_pkg::DIV_CODE_4:   half_period = CNT_WIDTH'(ssb_pkg::HALF_DIV_4);
      ssb_pkg::DIV_CODE_8:   half_period = CNT_WIDTH'(ssb_pkg::HALF_DIV_8);
      ssb_pkg::DIV_CODE_16:  half_period = CNT_WIDTH'(ssb_pkg::HALF_DIV_16);
      ssb_pkg::DIV_CODE_32:  half_period = CNT_WIDTH'(ssb_pkg::HALF_DIV_32);
      ssb_pkg::DIV_CODE_64:  half_period = CNT_WIDTH'(ssb_pkg::HALF_DIV_64);
      ssb_pkg::DIV_CODE_128: half_period = CNT_WIDTH'(ssb_pkg::HALF_DIV_128);
      // reserved codes never reach the divider
      default:               half_period = '0;
    endcase
  endfunction

  // reserved codes stop the divider
  function automatic logic code_valid(input logic [2:0] code);
    code_valid = (code != ssb_pkg::DIV_RSVD_LO) &&
                 (code != ssb_pkg::DIV_RSVD_HI);
  endfunction

  // only a fault-free master drives sck and mosi
  function automatic logic role_drives(input ssb_role_t role);
    role_drives = (role == ROLE_MASTER);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // synchronised pin and fault event
  logic pin_low;
  logic fault_event;
  logic drive_next;

  // sampled pin level, low means selected
  assign pin_low     = ~state.sync[LAST_SYNC];
  assign fault_event = master_enable & ~select_input_disable & pin_low; // RL5 RL6 RL13

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_state      = state;
    // select pin synchroniser
    next_state.sync = {state.sync[SYNC_STAGES-2:0], select_pin_n};

    // slave select; disable with cpha one means always selected
    next_state.selected = ~master_enable &
                          ((clock_phase & select_input_disable) | pin_low); // RL7

    // transmission start on select assertion in cpha zero
    next_state.start = ~master_enable & ~clock_phase &
                       next_state.selected & ~state.selected; // RL9

    // mode fault; held until explicit clear, set wins
    if (fault_clear) begin
      next_state.fault = 1'b0;
    end
    if (fault_event) begin // RL5 RL13
      next_state.fault = 1'b1;
    end

    // port role follows mode select and fault flag
    case (state.role)
      ROLE_SLAVE: begin
        if (master_enable && !next_state.fault) begin
          next_state.role = ROLE_MASTER;
        end else if (master_enable) begin
          next_state.role = ROLE_FAULT;
        end
      end
      ROLE_MASTER: begin
        if (!master_enable) begin
          next_state.role = ROLE_SLAVE;
        end else if (next_state.fault) begin
          next_state.role = ROLE_FAULT;
        end
      end
      ROLE_FAULT: begin
        if (!master_enable) begin
          next_state.role = ROLE_SLAVE;
        end else if (!next_state.fault) begin
          next_state.role = ROLE_MASTER;
        end
      end
      default: begin
        next_state.role = ROLE_SLAVE;
      end
    endcase

    // role decode
    drive_next = role_drives(next_state.role);

    // baud divider; reload after a half period
    if (drive_next && code_valid(clock_divider_select)) begin // RL11
      if (state.cnt >= half_period(clock_divider_select)) begin
        // toggle and reload at the end of a half period
        next_state.cnt = CNT_WIDTH'(ssb_pkg::CNT_RESET);
        next_state.sck = ~state.sck;
      end else begin
        // keep counting
        next_state.cnt = CNT_WIDTH'(state.cnt + 1'b1);
      end
    end else begin
      // idle low when not driving
      next_state.cnt = CNT_WIDTH'(ssb_pkg::CNT_RESET);
      next_state.sck = 1'b0;
    end

    // master drives only without fault
    next_state.sck_oe  = drive_next; // RL5 RL13
    next_state.mosi_oe = drive_next; // RL13
    next_state.mosi    = mosi_data;

    // slave floats miso when unselected
    next_state.miso_oe = next_state.selected; // RL4
    next_state.miso    = miso_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state      <= '0;
      // sync chain idles at pin high
      state.sync <= '1;
      state.role <= ROLE_SLAVE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status outputs
  // clearing select disable does not clear the fault flag
  assign mode_fault_flag = state.fault; // RL8
  assign slave_selected  = state.selected;
  assign transfer_start  = state.start;

  // serial clock
  assign sck_out         = state.sck;
  assign sck_oe          = state.sck_oe;

  // data lines
  assign mosi_out        = state.mosi;
  assign mosi_oe         = state.mosi_oe;
  assign miso_out        = state.miso;
  assign miso_oe         = state.miso_oe;

endmodule

// ===== tb/ssb_far_end.sv
`timescale 1ns/100ps
module ssb_far_end (input wire logic frame, output logic select_pin_n);
  // one slave, held low for the whole frame
  assign select_pin_n = !frame;
endmodule

// ===== tb/ssb_select_baud_assertions.sv
`timescale 1ns/100ps
module ssb_select_baud_assertions (
  input wire logic clk, reset_n, master_enable, clock_phase, select_input_disable, fault_clear, select_pin_n,
  input wire logic mode_fault_flag, slave_selected, transfer_start, sck_out, sck_oe, mosi_oe, miso_oe,
  input wire logic [2:0] clock_divider_select);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_miso_off: assert property (miso_oe |-> slave_selected) else $error("miso");
  chk_fault_set: assert property ((master_enable & !select_input_disable & !select_pin_n)[*4] |=> mode_fault_flag)
    else $error("set");
  chk_fault_why: assert property ($rose(mode_fault_flag) |-> !$past(select_input_disable)) else $error("why");
  chk_fault_stop: assert property (mode_fault_flag |-> !sck_oe && !mosi_oe) else $error("stop");
  chk_flag_keep: assert property (mode_fault_flag && !fault_clear |=> mode_fault_flag) else $error("keep");
  chk_cpha_sel: assert property ((clock_phase & select_input_disable & !master_enable)[*2] |=> slave_selected)
    else $error("sel");
  chk_start_once: assert property (transfer_start |-> !$past(clock_phase) ##1 !transfer_start) else $error("start");
  chk_div_four: assert property ((sck_oe && clock_divider_select == 3'h1)[*6] |-> sck_out != $past(sck_out, 2))
    else $error("div");
  cover property (transfer_start);
  cover property ($rose(mode_fault_flag));
  cover property ($rose(sck_out));
  cover property (slave_selected && miso_oe);
endmodule
bind ssb_select_baud ssb_select_baud_assertions ssb_select_baud_assertions_i (.*);

// ===== tb/ssb_select_baud_test.sv
`timescale 1ns/100ps
module ssb_select_baud_test;
  logic clk=0, reset_n=0, master_enable=0, clock_phase=0, select_input_disable=0, fault_clear=0;
  logic frame=0, miso_data=1, mosi_data=1, select_pin_n, mode_fault_flag, slave_selected, transfer_start;
  logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic [2:0] clock_divider_select=3'h1;
  int fail_count=0, samples_checked=0, n=0, k=0;
  ssb_select_baud ssb_select_baud_i (.*);
  ssb_far_end ssb_far_end_i (.*);
  initial forever #4 clk=~clk;
  always @(posedge clk) n++;
  task chk(logic s, e); samples_checked++; if (s!==e) begin fail_count++; $display("BAD %0t mismatch", $time); end endtask
  task w(int k); repeat (k) @(negedge clk); endtask
  task close_out; $display("%0d checks %0d bad", samples_checked, fail_count);
    if (fail_count==0 && samples_checked>0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish; endtask
  initial begin #20000 fail_count++; close_out; end
  initial begin w(8); reset_n=1;
    w(1); chk(miso_oe,0);
    frame=1; w(3); chk(transfer_start,1);
    w(1); chk(transfer_start,0);
    miso_data=0; w(1); chk(miso_out,0); chk(miso_oe,1);
    frame=0; w(4); chk(miso_oe,0);
    clock_phase=1; select_input_disable=1; w(2); chk(slave_selected,1); $display("slave end");
    master_enable=1; frame=1; w(5); chk(mode_fault_flag,0);
    mosi_data=0; w(1); chk(mosi_out,0); chk(mosi_oe,1);
    select_input_disable=0; w(5); chk(sck_oe,0);
    fault_clear=1; w(1); fault_clear=0; chk(mode_fault_flag,1);
    frame=0; select_input_disable=1; w(2); select_input_disable=0; w(2); chk(mode_fault_flag,1);
    fault_clear=1; w(1); fault_clear=0; w(2); $display("fault end");
    for (int c=1; c<7; c++) begin clock_divider_select=c[2:0]; repeat (2) @(posedge sck_out); k=n;
      @(posedge sck_out); chk(n-k==2<<c,1); @(negedge clk); end
    $display("divider end"); close_out; end
endmodule
